// [core/dosm_pkg.sv]
package dosm_pkg;

    // Operating states of the drive
    typedef enum logic [3:0] {
        ST_START,
        ST_NOT_READY,
        ST_ON_DISABLED,
        ST_READY,
        ST_SWITCHED_ON,
        ST_OP_ENABLED,
        ST_QUICK_STOP,
        ST_FAULT_REACT,
        ST_FAULT
    } dosm_state_t;

    // Numbers shown to software for each state
    localparam logic [3:0] CODE_START = 4'h1;
    localparam logic [3:0] CODE_NOT_READY = 4'h2;
    localparam logic [3:0] CODE_ON_DISABLED = 4'h3;
    localparam logic [3:0] CODE_READY = 4'h4;
    localparam logic [3:0] CODE_SWITCHED_ON = 4'h5;
    localparam logic [3:0] CODE_OP_ENABLED = 4'h6;
    localparam logic [3:0] CODE_QUICK_STOP = 4'h7;
    localparam logic [3:0] CODE_FAULT_REACT = 4'h8;
    localparam logic [3:0] CODE_FAULT = 4'h9;

    // Error classes
    localparam logic [2:0] ERR_WARN = 3'h0;
    localparam logic [2:0] ERR_QSTOP = 3'h1;
    localparam logic [2:0] ERR_QSTOP_OFF = 3'h2;
    localparam logic [2:0] ERR_FATAL = 3'h3;
    localparam logic [2:0] ERR_LOCKOUT = 3'h4;

    // Speed limit for readiness, in revolutions per minute
    localparam logic [15:0] SPEED_LIMIT_RPM = 16'h03E8;

    // Register map
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;

    // Control register fields
    localparam int CTRL_ENABLE = 0;
    localparam int CTRL_DISABLE = 1;
    localparam int CTRL_FAULT_RESET = 2;
    localparam int CTRL_CLR_WARN = 3;
    localparam int CTRL_FIELDBUS = 4;
    localparam int CTRL_BRAKE_FITTED = 5;
    localparam logic CTRL_FIELDBUS_RST = 1'b0;
    localparam logic CTRL_BRAKE_RST = 1'b0;

    // Status register fields
    localparam int STAT_CODE_LSB = 0;
    localparam int STAT_CODE_MSB = 3;
    localparam int STAT_POWER = 4;
    localparam int STAT_BRAKE_REL = 5;
    localparam int STAT_WARN = 6;
    localparam int STAT_LOCKOUT = 7;
    localparam int STAT_QSTOP = 8;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } dosm_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } dosm_apb_resp_t;

endpackage

// [core/dosm_state_machine.sv]
// The APB interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Class 0 error only records a warning; state and motion unchanged.
// - Class 1 error: quick stop to rest, power stage stays energised.
// - Class 2 error: quick stop, apply brake, power off at standstill.
// - Class 3 or 4 error: cut power at once, even during quick stop.
// - Class 4 lock-out is cleared only by power cycling, not fault reset.
// - Start goes to not-ready after electronics init, then disabled after params.
// - Disabled to ready: no undervoltage, encoder ok, speed under 1000, torque-off ok.
// - Enable request moves ready to switched-on, honoured only in ready.
// - Switched-on passes automatically to operation-enabled; power on, brake released.
// - Disable request in switched-on or operation-enabled returns to disabled.
// - Disable request in quick-stop-active goes to disabled, power cut at once.
// - Class 1 error in operation-enabled enters quick-stop-active, cancels motion.
// - Class 2, 3 or 4 error from any state other than fault-reaction-active and fault enters fault-reaction-active.
// - Fault reaction ends: class 2 after standstill, class 3 or 4 at once.
// - Torque-off trip acts like a class 3 error.
// - Fault reset in fault returns to disabled; cause removed beforehand.
// - Fault reset in quick-stop-active returns directly to operation-enabled.
// - Any one of several listed conditions suffices for a transition; disabled to ready here needs all four.
// - Fieldbus enable, disable and fault-reset requests act only in fieldbus control mode; warning clear acts in any mode.
module dosm_state_machine (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register bus
    input wire dosm_pkg::dosm_apb_req_t apbReq,
    output dosm_pkg::dosm_apb_resp_t apbResp,
    // Signal input requests
    input wire logic sigEnableReq,
    input wire logic sigDisableReq,
    input wire logic sigFaultReset,
    // Internal monitors
    input wire logic errValid,
    input wire logic [2:0] errClass,
    input wire logic electronicsInitDone,
    input wire logic paramInitDone,
    input wire logic underVoltage,
    input wire logic encoderOk,
    input wire logic [15:0] actualSpeed,
    input wire logic standstill,
    input wire logic [1:0] safeTorqueOffInputs,
    input wire logic torqueOffBypassJumper,
    // Drive outputs
    output logic powerStageOn,
    output logic brakeRelease,
    output logic quickStopCmd,
    output logic cancelMotion,
    output logic [3:0] stateCode,
    output logic warningFlag
);

    dosm_pkg::dosm_state_t state_reg;
    dosm_pkg::dosm_state_t state_next;
    logic severe_reg;
    logic severe_next;
    logic lockout_reg;
    logic fieldbus_reg;
    logic brakeFitted_reg;
    logic busEnable_reg;
    logic busDisable_reg;
    logic busFaultReset_reg;
    logic clrWarn_reg;
    logic [31:0] rdata_reg;
    logic slvErr;
    logic wrAccess;
    logic setupPhase;
    logic enableReq;
    logic disableReq;
    logic faultReset;
    logic stoOk;
    logic stoTrip;
    logic err0;
    logic err1;
    logic err2;
    logic errSevere;
    logic err4;
    logic readyOk;

    function automatic logic [3:0] codeOf(input dosm_pkg::dosm_state_t s);
        case (s)
            dosm_pkg::ST_START: codeOf = dosm_pkg::CODE_START;
            dosm_pkg::ST_NOT_READY: codeOf = dosm_pkg::CODE_NOT_READY;
            dosm_pkg::ST_ON_DISABLED: codeOf = dosm_pkg::CODE_ON_DISABLED;
            dosm_pkg::ST_READY: codeOf = dosm_pkg::CODE_READY;
            dosm_pkg::ST_SWITCHED_ON: codeOf = dosm_pkg::CODE_SWITCHED_ON;
            dosm_pkg::ST_OP_ENABLED: codeOf = dosm_pkg::CODE_OP_ENABLED;
            dosm_pkg::ST_QUICK_STOP: codeOf = dosm_pkg::CODE_QUICK_STOP;
            dosm_pkg::ST_FAULT_REACT: codeOf = dosm_pkg::CODE_FAULT_REACT;
            default: codeOf = dosm_pkg::CODE_FAULT;
        endcase
    endfunction

    // APB decode: zero wait states, read data latched in setup phase
    assign setupPhase = apbReq.psel && !apbReq.penable;
    assign wrAccess = apbReq.psel && apbReq.penable && apbReq.pwrite
        && (apbReq.paddr == dosm_pkg::ADDR_CTRL);
    assign slvErr = (apbReq.paddr != dosm_pkg::ADDR_CTRL)
        && !((apbReq.paddr == dosm_pkg::ADDR_STATUS) && !apbReq.pwrite);
    // One driver for the whole response word
    assign apbResp = '{prdata: rdata_reg, pready: 1'b1,
        pslverr: apbReq.psel && apbReq.penable && slvErr};

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdata_reg <= 32'h0000_0000;
        end else if (setupPhase) begin
            rdata_reg <= 32'h0000_0000;
            if (apbReq.paddr == dosm_pkg::ADDR_CTRL) begin
                rdata_reg[dosm_pkg::CTRL_FIELDBUS] <= fieldbus_reg;
                rdata_reg[dosm_pkg::CTRL_BRAKE_FITTED] <= brakeFitted_reg;
            end else if (apbReq.paddr == dosm_pkg::ADDR_STATUS) begin
                rdata_reg[dosm_pkg::STAT_CODE_MSB:dosm_pkg::STAT_CODE_LSB] <= stateCode;
                rdata_reg[dosm_pkg::STAT_POWER] <= powerStageOn;
                rdata_reg[dosm_pkg::STAT_BRAKE_REL] <= brakeRelease;
                rdata_reg[dosm_pkg::STAT_WARN] <= warningFlag;
                rdata_reg[dosm_pkg::STAT_LOCKOUT] <= lockout_reg;
                rdata_reg[dosm_pkg::STAT_QSTOP] <= quickStopCmd;
            end
        end
    end

    // Persistent control bits
    always_ff @(posedge clk) begin
        if (!rstn) begin
            fieldbus_reg <= dosm_pkg::CTRL_FIELDBUS_RST;
            brakeFitted_reg <= dosm_pkg::CTRL_BRAKE_RST;
        end else if (wrAccess) begin
            fieldbus_reg <= apbReq.pwdata[dosm_pkg::CTRL_FIELDBUS];
            brakeFitted_reg <= apbReq.pwdata[dosm_pkg::CTRL_BRAKE_FITTED];
        end
    end

    // Command bits from the bus act for one cycle after the write
    always_ff @(posedge clk) begin
        if (!rstn) begin
            busEnable_reg <= 1'b0;
            busDisable_reg <= 1'b0;
            busFaultReset_reg <= 1'b0;
            clrWarn_reg <= 1'b0;
        end else begin
            busEnable_reg <= wrAccess && apbReq.pwdata[dosm_pkg::CTRL_ENABLE];
            busDisable_reg <= wrAccess && apbReq.pwdata[dosm_pkg::CTRL_DISABLE];
            busFaultReset_reg <= wrAccess && apbReq.pwdata[dosm_pkg::CTRL_FAULT_RESET];
            clrWarn_reg <= wrAccess && apbReq.pwdata[dosm_pkg::CTRL_CLR_WARN];
        end
    end

    // Source selection: bus in fieldbus mode, signal inputs otherwise
    assign enableReq = fieldbus_reg ? busEnable_reg : sigEnableReq;
    assign disableReq = fieldbus_reg ? busDisable_reg : sigDisableReq;
    assign faultReset = fieldbus_reg ? busFaultReset_reg : sigFaultReset;

    // Error decode; classes above 4 are handled as lock-out
    assign err0 = errValid && (errClass == dosm_pkg::ERR_WARN);
    assign err1 = errValid && (errClass == dosm_pkg::ERR_QSTOP);
    assign err2 = errValid && (errClass == dosm_pkg::ERR_QSTOP_OFF);
    assign err4 = errValid && (errClass >= dosm_pkg::ERR_LOCKOUT);
    assign stoOk = (&safeTorqueOffInputs) || torqueOffBypassJumper;
    // Torque-off only trips while the power stage is live
    assign stoTrip = !stoOk && powerStageOn;
    assign errSevere = (errValid && (errClass >= dosm_pkg::ERR_FATAL)) || stoTrip;
    assign readyOk = !underVoltage && encoderOk
        && (actualSpeed < dosm_pkg::SPEED_LIMIT_RPM) && stoOk;

    always_comb begin
        state_next = state_reg;
        severe_next = severe_reg;
        if ((err2 || errSevere) && state_reg != dosm_pkg::ST_FAULT_REACT
                && state_reg != dosm_pkg::ST_FAULT) begin
            state_next = dosm_pkg::ST_FAULT_REACT;
            severe_next = errSevere;
        end else begin
            case (state_reg)
                dosm_pkg::ST_START: begin
                    if (electronicsInitDone) begin
                        state_next = dosm_pkg::ST_NOT_READY;
                    end
                end
                dosm_pkg::ST_NOT_READY: begin
                    if (paramInitDone) begin
                        state_next = dosm_pkg::ST_ON_DISABLED;
                    end
                end
                dosm_pkg::ST_ON_DISABLED: begin
                    if (readyOk) begin
                        state_next = dosm_pkg::ST_READY;
                    end
                end
                dosm_pkg::ST_READY: begin
                    if (underVoltage || !stoOk) begin
                        state_next = dosm_pkg::ST_ON_DISABLED;
                    end else if (enableReq) begin
                        state_next = dosm_pkg::ST_SWITCHED_ON;
                    end
                end
                dosm_pkg::ST_SWITCHED_ON: begin
                    if (disableReq) begin
                        state_next = dosm_pkg::ST_ON_DISABLED;
                    end else begin
                        state_next = dosm_pkg::ST_OP_ENABLED;
                    end
                end
                dosm_pkg::ST_OP_ENABLED: begin
                    if (disableReq) begin
                        state_next = dosm_pkg::ST_ON_DISABLED;
                    end else if (err1) begin
                        state_next = dosm_pkg::ST_QUICK_STOP;
                    end
                end
                dosm_pkg::ST_QUICK_STOP: begin
                    if (disableReq) begin
                        state_next = dosm_pkg::ST_ON_DISABLED;
                    end else if (faultReset) begin
                        state_next = dosm_pkg::ST_OP_ENABLED;
                    end
                end
                dosm_pkg::ST_FAULT_REACT: begin
                    if (errSevere) begin
                        severe_next = 1'b1;
                    end
                    if (severe_reg || errSevere || standstill) begin
                        state_next = dosm_pkg::ST_FAULT;
                    end
                end
                dosm_pkg::ST_FAULT: begin
                    if (faultReset && !lockout_reg) begin
                        state_next = dosm_pkg::ST_ON_DISABLED;
                        severe_next = 1'b0;
                    end
                end
                default: begin
                    state_next = dosm_pkg::ST_START;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            state_reg <= dosm_pkg::ST_START;
            severe_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            severe_reg <= severe_next;
        end
    end

    // Lock-out survives fault reset; only power-on reset clears it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            lockout_reg <= 1'b0;
        end else if (err4) begin
            lockout_reg <= 1'b1;
        end
    end

    // Warning flag: a new warning wins over a clear in the same cycle
    always_ff @(posedge clk) begin
        if (!rstn) begin
            warningFlag <= 1'b0;
        end else if (err0) begin
            warningFlag <= 1'b1;
        end else if (clrWarn_reg) begin
            warningFlag <= 1'b0;
        end
    end

    // Drive outputs, registered from the next state so they align with it
    always_ff @(posedge clk) begin
        if (!rstn) begin
            powerStageOn <= 1'b0;
            brakeRelease <= 1'b0;
            quickStopCmd <= 1'b0;
            cancelMotion <= 1'b0;
            stateCode <= dosm_pkg::CODE_START;
        end else begin
            stateCode <= codeOf(state_next);
            powerStageOn <= (state_next == dosm_pkg::ST_SWITCHED_ON)
                || (state_next == dosm_pkg::ST_OP_ENABLED)
                || (state_next == dosm_pkg::ST_QUICK_STOP)
                || (state_next == dosm_pkg::ST_FAULT_REACT && !severe_next);
            brakeRelease <= brakeFitted_reg && ((state_next == dosm_pkg::ST_OP_ENABLED)
                || (state_next == dosm_pkg::ST_QUICK_STOP));
            quickStopCmd <= (state_next == dosm_pkg::ST_QUICK_STOP)
                || (state_next == dosm_pkg::ST_FAULT_REACT && !severe_next);
            cancelMotion <= (state_next != state_reg)
                && ((state_next == dosm_pkg::ST_QUICK_STOP)
                || (state_next == dosm_pkg::ST_FAULT_REACT));
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_warn_keeps_state: assert property (
        (err0 && !err1 && !err2 && !errSevere && !enableReq && !disableReq && !faultReset
            && state_reg == dosm_pkg::ST_OP_ENABLED)
        |=> (state_reg == dosm_pkg::ST_OP_ENABLED) && warningFlag)
        else $error("warning changed the state");

    a_qstop_power_on: assert property (
        (state_reg == dosm_pkg::ST_QUICK_STOP) |-> powerStageOn && quickStopCmd)
        else $error("quick stop without power stage");

    a_class2_standstill: assert property (
        (state_reg == dosm_pkg::ST_FAULT_REACT && !severe_reg && !errSevere && !standstill)
        |=> powerStageOn && !brakeRelease)
        else $error("class 2 reaction dropped power early");

    a_severe_cuts_power: assert property (
        (errSevere && state_reg != dosm_pkg::ST_FAULT) |=> !powerStageOn
            && (state_reg == dosm_pkg::ST_FAULT_REACT || state_reg == dosm_pkg::ST_FAULT))
        else $error("power stage not cut on severe error");

    a_lockout_holds: assert property (
        (state_reg == dosm_pkg::ST_FAULT && lockout_reg) |=> state_reg == dosm_pkg::ST_FAULT)
        else $error("lock-out left fault state");

    a_init_order: assert property (
        (state_reg == dosm_pkg::ST_START && electronicsInitDone && !err2 && !errSevere)
        |=> (state_reg == dosm_pkg::ST_NOT_READY) && (stateCode == dosm_pkg::CODE_NOT_READY))
        else $error("start did not advance");

    a_ready_needs_ok: assert property (
        (state_reg == dosm_pkg::ST_ON_DISABLED) ##1 (state_reg == dosm_pkg::ST_READY)
        |-> $past(readyOk))
        else $error("ready entered without conditions");

    a_enable_only_ready: assert property (
        (state_reg == dosm_pkg::ST_SWITCHED_ON) |-> $past(state_reg) == dosm_pkg::ST_READY
            || $past(state_reg) == dosm_pkg::ST_SWITCHED_ON)
        else $error("switched-on entered from wrong state");

    a_auto_enable: assert property (
        (state_reg == dosm_pkg::ST_SWITCHED_ON && !disableReq && !err2 && !errSevere)
        |=> state_reg == dosm_pkg::ST_OP_ENABLED ##0 powerStageOn)
        else $error("no automatic enable");

    a_disable_qstop: assert property (
        (state_reg == dosm_pkg::ST_QUICK_STOP && disableReq && !err2 && !errSevere)
        |=> (state_reg == dosm_pkg::ST_ON_DISABLED) && !powerStageOn && !quickStopCmd)
        else $error("disable in quick stop not honoured");

    a_reset_to_enabled: assert property (
        (state_reg == dosm_pkg::ST_QUICK_STOP && faultReset && !disableReq
            && !err2 && !errSevere) |=> state_reg == dosm_pkg::ST_OP_ENABLED)
        else $error("fault reset did not resume operation");

    a_power_states: assert property (
        powerStageOn |-> (stateCode >= dosm_pkg::CODE_SWITCHED_ON)
            && (stateCode <= dosm_pkg::CODE_FAULT_REACT))
        else $error("power stage on in a wrong state");

endmodule

`default_nettype wire

// [bench/dosm_host_model.sv]
`timescale 1ns/1ps
`default_nettype none

module dosm_host_model (
    // Clock
    input wire logic clk,
    // Register bus
    output var dosm_pkg::dosm_apb_req_t apbReq,
    input wire dosm_pkg::dosm_apb_resp_t apbResp
);
    initial begin
        apbReq = '0;
    end

    // One transfer, held unchanged until pready is seen at a rising edge
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err, output logic ok);
        int n;
        ok = 1'b0;
        @(posedge clk);
        apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wdata};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge clk);
            ok = (apbResp.pready === 1'b1);
        end
        rdata = apbResp.prdata;
        err = apbResp.pslverr;
        // Released lines no longer show the last values
        apbReq <= '{psel: 1'b0, penable: 1'b0, pwrite: 1'b0, paddr: ~addr, pwdata: ~wdata};
    endtask
endmodule

`default_nettype wire

// [bench/test_dosm_state_machine.sv]
`timescale 1ns/1ps
`default_nettype none

module test_dosm_state_machine;
    typedef struct packed {
        logic ei, pi, uv, enc;
        logic [15:0] spd;
        logic [1:0] safe_torque_off_inputs;
        logic byp, st, en, dis, fr, ev;
        logic [2:0] ec;
        logic [3:0] code;
        logic pwr;
    } dosm_row_t;

    // Inputs beside the state and power stage they should give
    localparam dosm_row_t ROWS [29] = '{
        '{1,0,1,0,0,0,0,0,0,0,0,0,0,2,0}, '{1,1,1,0,0,0,0,0,0,0,0,0,0,3,0},
        '{1,1,0,1,1000,3,0,0,0,0,0,0,0,3,0}, '{1,1,0,1,999,3,0,0,0,0,0,0,0,4,0},
        '{1,1,0,1,999,1,0,0,0,0,0,0,0,3,0}, '{1,1,0,1,999,1,1,0,0,0,0,0,0,4,0},
        '{1,1,1,1,999,1,1,0,0,0,0,0,0,3,0}, '{1,1,0,1,999,3,0,0,0,0,0,0,0,4,0},
        '{1,1,0,1,999,3,0,0,1,0,0,0,0,6,1}, '{1,1,0,1,999,3,0,0,0,0,0,1,0,6,1},
        '{1,1,0,1,999,3,0,0,0,0,0,1,1,7,1}, '{1,1,0,1,999,3,0,0,0,0,1,0,0,6,1},
        '{1,1,0,1,999,3,0,0,0,1,0,0,0,3,0}, '{1,1,0,1,999,3,0,0,1,0,0,0,0,6,1},
        '{1,1,0,1,999,3,0,0,0,0,0,1,1,7,1}, '{1,1,0,1,999,3,0,0,0,1,0,0,0,3,0},
        '{1,1,0,1,999,3,0,0,1,0,0,0,0,6,1}, '{1,1,0,1,999,3,0,0,0,0,0,1,2,8,1},
        '{1,1,0,1,999,3,0,1,0,0,0,0,0,9,0}, '{1,1,0,1,999,3,0,1,0,0,1,0,0,3,0},
        '{1,1,0,1,999,3,0,1,1,0,0,0,0,6,1}, '{1,1,0,1,999,3,0,1,0,0,0,1,1,7,1},
        '{1,1,0,1,999,3,0,1,0,0,0,1,3,9,0}, '{1,1,0,1,999,3,0,1,0,0,1,0,0,3,0},
        '{1,1,0,1,999,3,0,1,1,0,0,0,0,6,1}, '{1,1,0,1,999,0,0,1,0,0,0,0,0,9,0},
        '{1,1,0,1,999,3,0,1,0,0,1,0,0,3,0}, '{1,1,0,1,999,3,0,1,1,0,0,0,0,6,1},
        '{1,1,0,1,999,3,0,1,0,0,0,1,4,9,0}
    };

    logic clk = 1'b0;
    logic rstn = 1'b0;
    dosm_pkg::dosm_apb_req_t apbReq;
    dosm_pkg::dosm_apb_resp_t apbResp;
    logic sigEnableReq, sigDisableReq, sigFaultReset, errValid;
    logic [2:0] errClass;
    logic electronicsInitDone, paramInitDone, underVoltage, encoderOk, standstill;
    logic [15:0] actualSpeed;
    logic [1:0] safeTorqueOffInputs;
    logic torqueOffBypassJumper, powerStageOn, brakeRelease, quickStopCmd, cancelMotion;
    logic [3:0] stateCode;
    logic warningFlag, er, ok;
    logic [31:0] rd;
    int badCount = 0;
    int checkCount = 0;

    always #50 clk = ~clk;

    dosm_host_model dosm_host_model_inst (.clk(clk), .apbReq(apbReq), .apbResp(apbResp));

    dosm_state_machine dosm_state_machine_inst (
        .clk(clk), .rstn(rstn), .apbReq(apbReq), .apbResp(apbResp),
        .sigEnableReq(sigEnableReq), .sigDisableReq(sigDisableReq),
        .sigFaultReset(sigFaultReset), .errValid(errValid), .errClass(errClass),
        .electronicsInitDone(electronicsInitDone), .paramInitDone(paramInitDone),
        .underVoltage(underVoltage), .encoderOk(encoderOk), .actualSpeed(actualSpeed),
        .standstill(standstill), .safeTorqueOffInputs(safeTorqueOffInputs),
        .torqueOffBypassJumper(torqueOffBypassJumper), .powerStageOn(powerStageOn),
        .brakeRelease(brakeRelease), .quickStopCmd(quickStopCmd),
        .cancelMotion(cancelMotion), .stateCode(stateCode), .warningFlag(warningFlag)
    );

    task automatic conclude();
        if (badCount == 0 && checkCount > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            badCount++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        dosm_host_model_inst.xfer(wr, a, d, rd, er, ok);
        if (ok !== 1'b1) begin
            badCount++;
            conclude();
        end
    endtask

    // Applies one row, pulses the error event once, waits for the state
    task automatic step(input dosm_row_t r);
        int n;
        @(posedge clk);
        {electronicsInitDone, paramInitDone, underVoltage, encoderOk, actualSpeed,
            safeTorqueOffInputs, torqueOffBypassJumper, standstill, sigEnableReq,
            sigDisableReq, sigFaultReset, errValid, errClass} <= r[35:5];
        @(posedge clk);
        errValid <= 1'b0;
        #1;
        for (n = 0; n < 10 && stateCode !== r.code; n++) begin
            @(posedge clk);
            #1;
        end
        cmp(stateCode, r.code);
        cmp(powerStageOn, r.pwr);
        if (stateCode !== r.code) begin
            conclude();
        end
    endtask

    task automatic doReset();
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        cmp(stateCode, dosm_pkg::CODE_START);
        cmp(powerStageOn, 1'b0);
        @(posedge clk);
        rstn <= 1'b1;
    endtask

    initial begin
        {electronicsInitDone, paramInitDone, underVoltage, encoderOk, actualSpeed,
            safeTorqueOffInputs, torqueOffBypassJumper, standstill, sigEnableReq,
            sigDisableReq, sigFaultReset, errValid, errClass} = '0;
        doReset();
        foreach (ROWS[i]) step(ROWS[i]);
        step('{1,1,0,1,999,3,0,1,0,0,1,0,0,9,0});
        repeat (4) @(posedge clk);
        #1;
        cmp(stateCode, dosm_pkg::CODE_FAULT);
        bus(1'b0, dosm_pkg::ADDR_STATUS, 32'h0000_0000);
        cmp(rd[dosm_pkg::STAT_LOCKOUT], 1'b1);
        doReset();
        step('{1,1,0,1,999,3,0,1,0,0,0,0,0,4,0});
        step('{1,1,0,1,999,3,0,1,1,0,0,0,0,6,1});
        step('{1,1,0,1,999,3,0,1,0,0,0,1,0,6,1});
        cmp(warningFlag, 1'b1);
        bus(1'b1, dosm_pkg::ADDR_CTRL, 32'h0000_0008);
        repeat (3) @(posedge clk);
        #1;
        cmp(warningFlag, 1'b0);
        bus(1'b1, dosm_pkg::ADDR_CTRL, 32'h0000_0010);
        bus(1'b0, dosm_pkg::ADDR_CTRL, 32'h0000_0000);
        cmp(rd, 32'h0000_0010);
        step('{1,1,0,1,999,3,0,1,0,1,0,0,0,6,1});
        step('{1,1,0,1,999,3,0,1,0,0,0,0,0,6,1});
        bus(1'b1, dosm_pkg::ADDR_CTRL, 32'h0000_0012);
        step('{1,1,0,1,999,3,0,1,0,0,0,0,0,4,0});
        bus(1'b1, dosm_pkg::ADDR_STATUS, 32'h0000_0000);
        cmp(er, 1'b1);
        bus(1'b0, 8'h08, 32'h0000_0000);
        cmp(er, 1'b1);
        bus(1'b0, dosm_pkg::ADDR_STATUS, 32'h0000_0000);
        cmp(rd[8:0], 9'h004);
        // Fieldbus enable with a brake fitted, then the motion outputs
        bus(1'b1, dosm_pkg::ADDR_CTRL, 32'h0000_0031);
        step('{1,1,0,1,999,3,0,0,0,0,0,0,0,6,1});
        cmp(brakeRelease, 1'b1);
        step('{1,1,0,1,999,3,0,0,0,0,0,1,1,7,1});
        cmp(cancelMotion, 1'b1);
        cmp(quickStopCmd, 1'b1);
        @(posedge clk);
        #1;
        cmp(cancelMotion, 1'b0);
        bus(1'b1, dosm_pkg::ADDR_CTRL, 32'h0000_0034);
        step('{1,1,0,1,999,3,0,0,0,0,0,0,0,6,1});
        step('{1,1,0,1,999,3,0,0,0,0,0,1,2,8,1});
        cmp(quickStopCmd, 1'b1);
        cmp(brakeRelease, 1'b0);
        cmp(cancelMotion, 1'b1);
        step('{1,1,0,1,999,3,0,1,0,0,0,0,0,9,0});
        bus(1'b1, dosm_pkg::ADDR_CTRL, 32'h0000_0034);
        step('{1,1,0,1,999,3,0,1,0,0,0,0,0,4,0});
        // Classes above 4 lock out as well
        step('{1,1,0,1,999,3,0,1,0,0,0,1,5,9,0});
        bus(1'b0, dosm_pkg::ADDR_STATUS, 32'h0000_0000);
        cmp(rd[dosm_pkg::STAT_LOCKOUT], 1'b1);
        conclude();
    end

    // Cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        badCount++;
        conclude();
    end
endmodule

`default_nettype wire
